// >>> rtl/rxfmc_pkg.sv
// constants, register map and carrier types of the receive framer control
package rxfmc_pkg;
    localparam int NUM_PORTS = 4;
    localparam int ADDR_W = 16;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_SA6 = 12'h06F;
    localparam logic [11:0] IDX_MASTER = 12'h080;
    localparam logic [11:0] IDX_CTRL1 = 12'h081;
    localparam logic [11:0] IDX_CTRL2 = 12'h082;
    localparam logic [11:0] IDX_CTRL3 = 12'h083;
    localparam logic [11:0] IDX_STATUS = 12'h0A0;
    localparam logic [11:0] PORT_STRIDE = 12'h200;
    localparam logic [11:0] PORT_FIELD = 12'h600;
    localparam logic [7:0] REG_RESET = 8'h00;
    // writable masks; reserved bits read as zero
    localparam logic [7:0] MASK_MASTER = 8'hC3;
    localparam logic [7:0] MASK_C1_T1 = 8'hFF;
    localparam logic [7:0] MASK_C1_E1 = 8'h7F;
    localparam logic [7:0] MASK_C2_T1 = 8'h3F;
    localparam logic [7:0] MASK_C2_E1 = 8'hF9;
    localparam logic [7:0] MASK_C3 = 8'hA3;
    // master mode fields
    localparam int MM_FRAMER_EN = 7;
    localparam int MM_INIT_DONE = 6;
    localparam int MM_SOFT_RST = 1;
    localparam int MM_STD_SEL = 0;
    // control one, t1 and e1 meanings
    localparam int C1_SYNC_QUAL = 7;
    localparam int C1_HDB3 = 6;
    localparam int C1_B8ZS = 6;
    localparam int C1_FMT = 5;
    localparam int C1_ARC = 4;
    localparam int C1_G802 = 4;
    localparam int C1_SYNC_SEARCH_CRITERIA = 3;
    localparam int C1_CRC4 = 3;
    localparam int C1_JCRC = 2;
    localparam int C1_FRC = 2;
    localparam int C1_NOAUTO = 1;
    localparam int C1_RESYNC = 0;
    localparam int C2_UP_LSB = 3;
    localparam int C2_LOSA = 0;
    // line timing
    localparam logic [7:0] T1_LAST_BIT = 8'd192;
    localparam logic [7:0] E1_LAST_BIT = 8'd255;
    localparam logic [4:0] D4_LAST_FRM = 5'd11;
    localparam logic [4:0] ESF_LAST_FRM = 5'd23;
    localparam logic [4:0] E1_LAST_FRM = 5'd15;
    localparam logic [7:0] E1_TS0_END = 8'd7;
    localparam logic [7:0] SA4_BIT = 8'd3;
    localparam logic [7:0] SA6_BIT = 8'd5;
    localparam logic [7:0] SA8_BIT = 8'd7;
    localparam logic [7:0] SLOT26_BIT1 = 8'd208;
    localparam logic [6:0] E1_FAS = 7'h1B;
    localparam logic [11:0] D4_PATTERN = 12'h8DC;
    localparam logic [5:0] ESF_FPS = 6'h0B;
    localparam logic [4:0] QUAL_SHORT = 5'd10;
    localparam logic [4:0] QUAL_LONG = 5'd24;
    localparam logic [4:0] QUAL_E1 = 5'd2;
    localparam logic [1:0] ERR_LIMIT = 2'd3;
    localparam logic [11:0] LOS_E1_SHORT = 12'd255;
    localparam logic [11:0] LOS_E1_LONG = 12'd2048;
    localparam logic [11:0] LOS_T1 = 12'd192;
    localparam logic [11:0] ZCNT_MAX = 12'hFFF;
    localparam logic [7:0] CLR_ZSUB_E1 = 8'h09;
    localparam logic [7:0] CLR_ZSUB_T1 = 8'h1B;
    localparam logic [5:0] CRC_MASK_T1 = 6'h3F;
    localparam logic [5:0] CRC_MASK_E1 = 6'h0F;

    typedef struct packed {
        logic [7:0] master;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
    } rxfmc_cfg_t;

    typedef struct packed {
        logic in_sync;
        logic los;
        logic crc_err;
        logic [3:0] sa6;
    } rxfmc_stat_t;

    typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_QUAL, ST_SYNC} rxfmc_state_t;
endpackage : rxfmc_pkg

// >>> rtl/rxfmc_top.sv
// four-port receive framer with apb register file
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module rxfmc_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire rxfmc_pkg::rxfmc_cfg_t cfg,
    input wire logic line_clk,
    input wire logic line_pos,
    input wire logic line_neg,
    output var rxfmc_pkg::rxfmc_stat_t stat,
    output logic rx_data,
    output logic dl_clk,
    output logic blank_out
);
    logic [2:0] clk_s;
    logic [2:0] pos_s;
    logic [2:0] neg_s;
    logic clk_f;
    logic resync_d;
    logic resync_pend;
    logic last_pol;
    logic [7:0] mk;
    logic [7:0] vf;
    logic [7:0] win;
    logic [11:0] zcnt;
    logic [7:0] bit_pos;
    logic [4:0] frm;
    logic [4:0] qcnt;
    logic [1:0] ecnt;
    logic [5:0] crc;
    logic [5:0] crc_prev;
    logic [5:0] rcv;
    rxfmc_pkg::rxfmc_state_t state;

    // a level counts only once the second and third stages agree
    wire stable = clk_s[1] == clk_s[2];
    wire tick = stable && clk_s[1] && !clk_f;
    wire pos_in = pos_s[2];
    wire mark_in = pos_s[2] | neg_s[2];

    wire e1 = cfg.master[rxfmc_pkg::MM_STD_SEL];
    wire run = cfg.master[rxfmc_pkg::MM_INIT_DONE] & cfg.master[rxfmc_pkg::MM_FRAMER_EN]
        & ~cfg.master[rxfmc_pkg::MM_SOFT_RST];
    wire esf = ~cfg.ctrl1[rxfmc_pkg::C1_FMT];
    wire sync_search_criteria = cfg.ctrl1[rxfmc_pkg::C1_SYNC_SEARCH_CRITERIA];
    wire auto_ok = ~cfg.ctrl1[rxfmc_pkg::C1_NOAUTO];
    wire resync_req = cfg.ctrl1[rxfmc_pkg::C1_RESYNC] & ~resync_d;

    // zero substitution removal over an eight-bit delay line
    wire viol = mark_in & (pos_in == last_pol);
    wire [7:0] mk_sh = {mk[6:0], mark_in};
    wire [7:0] vf_sh = {vf[6:0], viol};
    wire hdb_hit = e1 & cfg.ctrl1[rxfmc_pkg::C1_HDB3] & vf_sh[0];
    wire b8_hit = ~e1 & cfg.ctrl1[rxfmc_pkg::C1_B8ZS] & vf_sh[1] & vf_sh[4] & mk_sh[0];
    wire [7:0] clr = hdb_hit ? rxfmc_pkg::CLR_ZSUB_E1 : (b8_hit ? rxfmc_pkg::CLR_ZSUB_T1 : 8'h00);
    wire d = mk[7];
    wire [7:0] win_n = {win[6:0], d};

    // loss of signal threshold
    wire [11:0] los_lim = e1 ? (cfg.ctrl2[rxfmc_pkg::C2_LOSA] ? rxfmc_pkg::LOS_E1_LONG
        : rxfmc_pkg::LOS_E1_SHORT) : rxfmc_pkg::LOS_T1;
    wire los_now = zcnt >= los_lim;

    // frame position
    wire [7:0] last_bit = e1 ? rxfmc_pkg::E1_LAST_BIT : rxfmc_pkg::T1_LAST_BIT;
    wire [4:0] last_frm = e1 ? rxfmc_pkg::E1_LAST_FRM
        : (esf ? rxfmc_pkg::ESF_LAST_FRM : rxfmc_pkg::D4_LAST_FRM);
    wire end_bit = bit_pos == last_bit;
    wire end_frm = frm == last_frm;
    wire fas_frm = ~frm[0];

    // t1 framing bit check
    wire [2:0] fps_idx = 3'(frm[4:2]);
    wire exp_esf = rxfmc_pkg::ESF_FPS[3'd5 - fps_idx];
    wire exp_d4 = rxfmc_pkg::D4_PATTERN[4'd11 - 4'(frm[3:0])];
    wire d4_chk = ~frm[0] | sync_search_criteria | (state == rxfmc_pkg::ST_SYNC);
    wire t1_chk = ~e1 && bit_pos == 8'd0 && (esf ? frm[1:0] == 2'd3 : d4_chk);
    wire t1_ok = d == (esf ? exp_esf : exp_d4);

    // e1 alignment word check
    wire fas_hit = win_n[6:0] == rxfmc_pkg::E1_FAS;
    wire e1_at = e1 && bit_pos == rxfmc_pkg::E1_TS0_END;
    wire frame_resync_criteria = cfg.ctrl1[rxfmc_pkg::C1_FRC];
    wire e1_chk = e1_at && (fas_frm || frame_resync_criteria || state != rxfmc_pkg::ST_SYNC);
    wire e1_ok = fas_frm ? fas_hit : win_n[6];

    wire chk = t1_chk | e1_chk;
    wire chk_ok = e1 ? e1_ok : t1_ok;
    wire [4:0] qual_target = e1 ? rxfmc_pkg::QUAL_E1
        : (cfg.ctrl1[rxfmc_pkg::C1_SYNC_QUAL] ? rxfmc_pkg::QUAL_LONG : rxfmc_pkg::QUAL_SHORT);

    // crc-6 for t1 esf, crc-4 for e1; both share the x+1 low terms
    wire jcrc = cfg.ctrl1[rxfmc_pkg::C1_JCRC];
    wire [5:0] crc_mask = e1 ? rxfmc_pkg::CRC_MASK_E1 : rxfmc_pkg::CRC_MASK_T1;
    wire crc_din = (bit_pos != 8'd0) ? d : (e1 ? (frm[0] & d) : (~jcrc | d));
    wire crc_fb = (e1 ? crc[3] : crc[5]) ^ crc_din;
    wire [5:0] crc_n = ({crc[4:0], 1'b0} ^ {4'h0, crc_fb, crc_fb}) & crc_mask;
    wire crc_on = e1 ? cfg.ctrl1[rxfmc_pkg::C1_CRC4] : esf;
    wire rcv_at = bit_pos == 8'd0 && (e1 ? fas_frm : frm[1:0] == 2'd1);
    wire blk_end = end_bit && (e1 ? frm[2:0] == 3'd7 : end_frm);
    wire crc_bad = ((rcv & crc_mask) != crc_prev);

    // resync causes
    wire oof = chk && !chk_ok && ecnt == (rxfmc_pkg::ERR_LIMIT - 2'd1);
    wire auto_cause = oof | (~e1 & ~cfg.ctrl1[rxfmc_pkg::C1_ARC] & los_now);
    wire lose = resync_pend | (auto_ok & auto_cause);

    wire sa_bit = e1 && !fas_frm && bit_pos >= rxfmc_pkg::SA4_BIT && bit_pos <= rxfmc_pkg::SA8_BIT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_s <= 3'h0;
            pos_s <= 3'h0;
            neg_s <= 3'h0;
            clk_f <= 1'b0;
            resync_d <= 1'b0;
        end else begin
            clk_s <= {clk_s[1:0], line_clk};
            pos_s <= {pos_s[1:0], line_pos};
            neg_s <= {neg_s[1:0], line_neg};
            if (stable) begin
                clk_f <= clk_s[1];
            end
            resync_d <= cfg.ctrl1[rxfmc_pkg::C1_RESYNC];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_pend <= 1'b0;
        end else if (!run) begin
            resync_pend <= 1'b0;
        end else if (resync_req) begin
            resync_pend <= 1'b1;
        end else if (tick) begin
            resync_pend <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_pol <= 1'b0;
            mk <= 8'h00;
            vf <= 8'h00;
            win <= 8'h00;
            zcnt <= 12'h000;
        end else if (!run) begin
            last_pol <= 1'b0;
            mk <= 8'h00;
            vf <= 8'h00;
            win <= 8'h00;
            zcnt <= 12'h000;
        end else if (tick) begin
            if (mark_in) begin
                last_pol <= pos_in;
            end
            mk <= mk_sh & ~clr;
            vf <= vf_sh;
            win <= win_n;
            zcnt <= mark_in ? 12'h000 : ((zcnt == rxfmc_pkg::ZCNT_MAX) ? zcnt : zcnt + 12'h001);
        end
    end

    // framing state machine; held idle while the framer is not running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rxfmc_pkg::ST_OFF;
            bit_pos <= 8'h00;
            frm <= 5'h00;
            qcnt <= 5'h00;
            ecnt <= 2'h0;
        end else if (!run) begin
            state <= rxfmc_pkg::ST_OFF;
            bit_pos <= 8'h00;
            frm <= 5'h00;
            qcnt <= 5'h00;
            ecnt <= 2'h0;
        end else if (tick) begin
            if (end_bit) begin
                bit_pos <= 8'h00;
                frm <= end_frm ? 5'h00 : frm + 5'h01;
            end else begin
                bit_pos <= bit_pos + 8'h01;
            end
            case (state)
                rxfmc_pkg::ST_OFF: begin
                    state <= rxfmc_pkg::ST_HUNT;
                end
                rxfmc_pkg::ST_HUNT: begin
                    qcnt <= 5'h00;
                    ecnt <= 2'h0;
                    if (e1 && fas_hit) begin
                        bit_pos <= rxfmc_pkg::E1_TS0_END + 8'h01;
                        frm <= 5'h00;
                        qcnt <= 5'h01;
                        state <= rxfmc_pkg::ST_QUAL;
                    end else if (t1_chk) begin
                        if (t1_ok) begin
                            qcnt <= 5'h01;
                            state <= rxfmc_pkg::ST_QUAL;
                        end else begin
                            bit_pos <= bit_pos; // slip one bit
                        end
                    end
                end
                rxfmc_pkg::ST_QUAL: begin
                    if (resync_pend) begin
                        state <= rxfmc_pkg::ST_HUNT;
                    end else if (~e1 && esf && sync_search_criteria && blk_end && crc_bad) begin
                        state <= rxfmc_pkg::ST_HUNT;
                    end else if (chk) begin
                        if (!chk_ok) begin
                            state <= rxfmc_pkg::ST_HUNT;
                        end else if (qcnt + 5'h01 >= qual_target) begin
                            state <= rxfmc_pkg::ST_SYNC;
                        end else begin
                            qcnt <= qcnt + 5'h01;
                        end
                    end
                end
                rxfmc_pkg::ST_SYNC: begin
                    if (lose) begin
                        state <= rxfmc_pkg::ST_HUNT;
                    end else if (chk) begin
                        ecnt <= chk_ok ? 2'h0 : ecnt + 2'h1;
                    end
                end
                default: begin
                    state <= rxfmc_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= 6'h00;
            crc_prev <= 6'h00;
            rcv <= 6'h00;
            stat <= '0;
            rx_data <= 1'b0;
            dl_clk <= 1'b0;
            blank_out <= 1'b0;
        end else if (!run) begin
            crc <= 6'h00;
            crc_prev <= 6'h00;
            rcv <= 6'h00;
            stat <= '0;
            rx_data <= 1'b0;
            dl_clk <= 1'b0;
            blank_out <= 1'b0;
        end else begin
            stat.in_sync <= state == rxfmc_pkg::ST_SYNC;
            stat.los <= los_now;
            if (tick) begin
                rx_data <= d;
                // data link clock stays high for the whole selected bit
                dl_clk <= sa_bit && cfg.ctrl2[bit_pos[2:0]] && state == rxfmc_pkg::ST_SYNC;
                blank_out <= e1 && cfg.ctrl1[rxfmc_pkg::C1_G802] && bit_pos == rxfmc_pkg::SLOT26_BIT1;
                if (e1 && !fas_frm && bit_pos == rxfmc_pkg::SA6_BIT) begin
                    // free-running window, not aligned to the submultiframe
                    stat.sa6 <= {stat.sa6[2:0], d};
                end
                if (rcv_at) begin
                    rcv <= {rcv[4:0], d};
                end
                if (blk_end) begin
                    stat.crc_err <= crc_on && state == rxfmc_pkg::ST_SYNC && crc_bad;
                    crc_prev <= crc_n;
                    crc <= 6'h00;
                end else begin
                    crc <= crc_n;
                end
            end
        end
    end
endmodule : rxfmc_port

// Overview of operation
// - Sa6 codeword reported as last four Sa6 bits, any rotation possible.
// - framer enable clear holds the framer idle; set runs it only with initialization done set and soft reset clear.
// - configuration is acted on only once initialization done is set.
// - soft reset is a level; receiver held in reset while it is one.
// - mode bit picks T1 at zero, E1 at one; control meanings follow.
// - T1 sync declared after 10 or 24 qualified framing bits.
// - T1 zero substitution decoded only when its enable is set.
// - T1 format bit selects ESF at zero, D4 at one.
// - T1 auto resync on loss of frame or signal, or frame only.
// - sync criteria bit picks Ft-then-Fs or coupled; FPS alone or with CRC.
// - CRC-6 uses standard or Japanese variant per select bit.
// - sync enable bit zero allows auto resync, one forbids it.
// - rising edge of resync bit starts one resynchronization.
// - E1 HDB3 decoded only when its enable is set.
// - E1 signaling bit (CAS at zero, CCS at one) is stored only; no framing logic reads it.
// - G.802 bit forces channel blanking high on slot 26 bit 1.
// - E1 CRC-4 checking performed only when enabled.
// - E1 resync after three bad FAS words, optionally counting non-FAS bit 2.
// - loop code length fields (code plus one bits, 111 for 8 or 16) are stored only; no loop code detection.
// - each Sa select bit gates the data link clock at its position.
// - E1 loss of signal after 255 or 2048 consecutive zeros.
// - four independent port copies of the controls at stride 200h.
module rxfmc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rxfmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [rxfmc_pkg::NUM_PORTS-1:0] rx_line_clk,
    input wire logic [rxfmc_pkg::NUM_PORTS-1:0] rx_line_pos,
    input wire logic [rxfmc_pkg::NUM_PORTS-1:0] rx_line_neg,
    output logic [rxfmc_pkg::NUM_PORTS-1:0] rx_serial_data,
    output logic [rxfmc_pkg::NUM_PORTS-1:0] rx_data_link_bit_clock,
    output logic [rxfmc_pkg::NUM_PORTS-1:0] rx_channel_blank_out
);
    rxfmc_pkg::rxfmc_cfg_t cfg_reg [rxfmc_pkg::NUM_PORTS];
    rxfmc_pkg::rxfmc_stat_t stat_w [rxfmc_pkg::NUM_PORTS];

    wire [11:0] idx = paddr[13:2];
    wire [1:0] port = idx[10:9];
    wire [11:0] loc = idx & ~rxfmc_pkg::PORT_FIELD;
    wire aligned = paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00;
    wire h_mm = aligned && loc == rxfmc_pkg::IDX_MASTER;
    wire h_c1 = aligned && loc == rxfmc_pkg::IDX_CTRL1;
    wire h_c2 = aligned && loc == rxfmc_pkg::IDX_CTRL2;
    wire h_c3 = aligned && loc == rxfmc_pkg::IDX_CTRL3;
    wire h_sa6 = aligned && loc == rxfmc_pkg::IDX_SA6;
    wire h_st = aligned && loc == rxfmc_pkg::IDX_STATUS;
    wire mapped = h_mm | h_c1 | h_c2 | h_c3 | h_sa6 | h_st;

    wire rxfmc_pkg::rxfmc_cfg_t sel_cfg = cfg_reg[port];
    wire rxfmc_pkg::rxfmc_stat_t sel_st = stat_w[port];
    wire sel_e1 = sel_cfg.master[rxfmc_pkg::MM_STD_SEL];
    wire [7:0] rd_byte = h_mm ? sel_cfg.master
        : h_c1 ? sel_cfg.ctrl1
        : h_c2 ? sel_cfg.ctrl2
        : h_c3 ? sel_cfg.ctrl3
        : h_sa6 ? {4'h0, sel_st.sa6}
        : h_st ? {5'h00, sel_st.crc_err, sel_st.los, sel_st.in_sync}
        : 8'h00;
    // shared offsets keep only the bits defined for the current mode
    wire [7:0] wmask = h_mm ? rxfmc_pkg::MASK_MASTER
        : h_c1 ? (sel_e1 ? rxfmc_pkg::MASK_C1_E1 : rxfmc_pkg::MASK_C1_T1)
        : h_c2 ? (sel_e1 ? rxfmc_pkg::MASK_C2_E1 : rxfmc_pkg::MASK_C2_T1)
        : h_c3 ? rxfmc_pkg::MASK_C3
        : 8'h00;
    wire [7:0] wbyte = pwdata[7:0] & wmask;
    wire setup = psel & ~penable;
    wire wr = psel & penable & pready & pwrite & pstrb[0] & mapped;

    // no wait state: read data and error are registered in the setup cycle so that they come from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < rxfmc_pkg::NUM_PORTS; i++) begin
                cfg_reg[i] <= {4{rxfmc_pkg::REG_RESET}};
            end
        end else if (wr) begin
            for (int i = 0; i < rxfmc_pkg::NUM_PORTS; i++) begin
                if (port == 2'(i)) begin
                    if (h_mm) cfg_reg[i].master <= wbyte;
                    if (h_c1) cfg_reg[i].ctrl1 <= wbyte;
                    if (h_c2) cfg_reg[i].ctrl2 <= wbyte;
                    if (h_c3) cfg_reg[i].ctrl3 <= wbyte;
                end
            end
        end
    end

    for (genvar g = 0; g < rxfmc_pkg::NUM_PORTS; g++) begin : g_port
        rxfmc_port u_port (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(cfg_reg[g]),
            .line_clk(rx_line_clk[g]),
            .line_pos(rx_line_pos[g]),
            .line_neg(rx_line_neg[g]),
            .stat(stat_w[g]),
            .rx_data(rx_serial_data[g]),
            .dl_clk(rx_data_link_bit_clock[g]),
            .blank_out(rx_channel_blank_out[g])
        );
    end
endmodule : rxfmc_top

`default_nettype wire

// >>> tb/rxfmc_asserts.sv
// bus and line output checks for the receive framer control
`timescale 1ns/10ps
`default_nettype none
module rxfmc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [rxfmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [rxfmc_pkg::NUM_PORTS-1:0] rx_data_link_bit_clock,
    input wire logic [rxfmc_pkg::NUM_PORTS-1:0] rx_channel_blank_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup;
    assign setup = psel && !penable;
    property p_ans; setup |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_aln; setup && paddr[1:0] != 2'b00 |=> pslverr; endproperty
    a_aln: assert property (p_aln) else $error("misaligned not refused");
    property p_top; setup && paddr[15:14] != 2'b00 |=> pslverr; endproperty
    a_top: assert property (p_top) else $error("high address not refused");
    property p_hi; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_blk; $rose(rx_channel_blank_out[0]) |-> rx_channel_blank_out[0] [*6] ##[1:4] !rx_channel_blank_out[0]; endproperty
    a_blk: assert property (p_blk) else $error("blank pulse not one line bit");
    property p_lnk; $rose(rx_data_link_bit_clock[0]) |-> rx_data_link_bit_clock[0] [*6] ##[1:4] !rx_data_link_bit_clock[0]; endproperty
    a_lnk: assert property (p_lnk) else $error("link clock pulse not one line bit");
    c_err: cover property (setup && paddr[1:0] != 2'b00);
    c_blk: cover property ($rose(rx_channel_blank_out[0]));
    c_lnk: cover property ($rose(rx_data_link_bit_clock[0]));
endmodule : rxfmc_asserts
bind rxfmc_top rxfmc_asserts i_rxfmc_asserts (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .rx_data_link_bit_clock, .rx_channel_blank_out);
`default_nettype wire

// >>> tb/rxfmc_line_model.sv
// E1 line source: AMI marks, FAS framing, alternating Sa6 bits
`timescale 1ns/10ps
`default_nettype none
module rxfmc_line_model (
    input wire logic run,
    input wire logic zeros,
    output logic lclk,
    output logic pos,
    output logic neg
);
    int bitn = 0;
    int frm = 0;
    logic pol = 1'b0;
    logic b;
    initial begin
        lclk = 1'b0;
        pos = 1'b0;
        neg = 1'b0;
    end
    // clock stands low until the source runs
    always #400 lclk = run & ~lclk;
    always @(negedge lclk) begin
        b = 1'b1;
        if (frm % 2 == 0 && bitn >= 1 && bitn <= 7) b = rxfmc_pkg::E1_FAS[7 - bitn];
        else if (frm % 2 == 1 && bitn == 2) b = 1'b0;
        else if (frm % 2 == 1 && bitn == 5) b = frm[1];
        if (zeros) b = 1'b0;
        pos <= b & ~pol;
        neg <= b & pol;
        pol = pol ^ b;
        bitn = (bitn + 1) % 256;
        if (bitn == 0) frm = (frm + 1) % 16;
    end
endmodule : rxfmc_line_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: registers, E1 framing, resync, loss of signal
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [15:0] P1 = 16'(rxfmc_pkg::PORT_STRIDE) << 2;
    localparam logic [15:0] A_MM = 16'(rxfmc_pkg::IDX_MASTER) << 2;
    localparam logic [15:0] A_C1 = 16'(rxfmc_pkg::IDX_CTRL1) << 2;
    localparam logic [15:0] A_C2 = 16'(rxfmc_pkg::IDX_CTRL2) << 2;
    localparam logic [15:0] A_C3 = 16'(rxfmc_pkg::IDX_CTRL3) << 2;
    localparam logic [15:0] A_SA = 16'(rxfmc_pkg::IDX_SA6) << 2;
    localparam logic [15:0] A_ST = 16'(rxfmc_pkg::IDX_STATUS) << 2;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, zeros = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, lclk, lpos, lneg, e;
    logic [3:0] sdata, dlclk, blank, bseen, dseen, sseen;
    logic [7:0] q;
    int err_total = 0;
    int comparisons = 0;
    always #50 pclk = ~pclk;
    rxfmc_line_model i_rxfmc_line_model (.run(run), .zeros(zeros), .lclk(lclk), .pos(lpos), .neg(lneg));
    rxfmc_top i_rxfmc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line_clk({4{lclk}}), .rx_line_pos({4{lpos}}), .rx_line_neg({4{lneg}}), .rx_serial_data(sdata),
        .rx_data_link_bit_clock(dlclk), .rx_channel_blank_out(blank));
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 20) begin
                err_total++;
                summarize();
            end
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_sync;
        int n;
        n = 0;
        do begin
            apb(1'b0, A_ST, 8'h00);
            n++;
            if (n > 8000) begin
                err_total++;
                summarize();
            end
        end while (q[0] !== 1'b1);
    endtask : wait_sync
    task automatic watch(input int cyc);
        bseen = 4'h0;
        dseen = 4'h0;
        sseen = 4'h0;
        repeat (cyc) begin
            @(negedge pclk);
            sseen |= sdata;
            bseen |= blank;
            dseen |= dlclk;
        end
    endtask : watch
    task automatic t_regs;
        apb(1'b0, A_MM, 8'h00);
        chk("master reset", 8'h00, q);
        apb(1'b1, A_C3, 8'hFF);
        apb(1'b0, A_C3, 8'h00);
        chk("ctrl3 mask", rxfmc_pkg::MASK_C3, q);
        apb(1'b0, A_C3 + P1, 8'h00);
        chk("port1 ctrl3", 8'h00, q);
        apb(1'b0, A_MM + 16'h0002, 8'h00);
        chk("misaligned err", 8'h01, {7'h00, e});
        apb(1'b0, A_MM | 16'h4000, 8'h00);
        chk("high addr err", 8'h01, {7'h00, e});
    endtask : t_regs
    task automatic t_e1;
        apb(1'b1, A_MM, 8'h01);
        apb(1'b1, A_C1, 8'hFF);
        apb(1'b0, A_C1, 8'h00);
        chk("e1 ctrl1 mask", 8'h7F, q);
        apb(1'b1, A_C1, 8'h10);
        apb(1'b1, A_C2, 8'h20);
        apb(1'b1, A_MM, 8'h81);
        run <= 1'b1;
        watch(6200);
        apb(1'b0, A_ST, 8'h00);
        chk("no sync before init", 8'h00, {7'h00, q[0]});
        apb(1'b1, A_MM, 8'hC1);
        wait_sync();
        watch(16400);
        apb(1'b0, A_SA, 8'h00);
        chk("sa6 code", 8'h01, {7'h00, q == 8'h05 || q == 8'h0A});
        chk("slot26 blank", 8'h01, {7'h00, bseen[0]});
        chk("sa6 link clock", 8'h01, {7'h00, dseen[0]});
        chk("serial data", 8'h01, {7'h00, sseen[0]});
        chk("port1 idle", 8'h00, {5'h00, sseen[1], bseen[1], dseen[1]});
    endtask : t_e1
    task automatic t_resync;
        apb(1'b1, A_C1, 8'h01);
        repeat (30) @(posedge pclk);
        apb(1'b0, A_ST, 8'h00);
        chk("resync hunts", 8'h00, {7'h00, q[0]});
        apb(1'b1, A_C1, 8'h00);
        wait_sync();
        apb(1'b1, A_MM, 8'hC3);
        apb(1'b0, A_ST, 8'h00);
        chk("soft reset holds", 8'h00, {7'h00, q[0]});
        apb(1'b1, A_MM, 8'hC1);
        wait_sync();
    endtask : t_resync
    task automatic t_los;
        int thr;
        apb(1'b1, A_C1, 8'h02);
        for (int k = 0; k < 2; k++) begin
            thr = (k == 0) ? 255 : 2048;
            apb(1'b1, A_C2, 8'h20 | 8'(k));
            zeros <= 1'b1;
            repeat ((thr - 12) * 8) @(posedge pclk);
            apb(1'b0, A_ST, 8'h00);
            chk("los early", 8'h01, {6'h00, q[1:0]});
            repeat (24 * 8) @(posedge pclk);
            apb(1'b0, A_ST, 8'h00);
            chk("los declared", 8'h03, {6'h00, q[1:0]});
            zeros <= 1'b0;
            repeat (80) @(posedge pclk);
        end
    endtask : t_los
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_e1();
        t_resync();
        t_los();
        summarize();
    end
endmodule : tb
`default_nettype wire
